// *** rtl/fatc_core.sv ***
// frame acquisition and trigger controller with wishbone registers
`timescale 1ns/1ps
module fatc_core #(
    parameter int NLINES = 4
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // trigger input lines
    input  wire logic [NLINES-1:0] line_in,
    // status outputs
    output logic                   acquiring,
    output logic                   exposure_active,
    output logic                   frame_done_p
);
    // ============================================================
    // elaboration check: line select field is two bits
    if (NLINES < 1 || NLINES > 4) begin : g_chk
        $error("fatc_core: NLINES must be 1 to 4");
    end

    // ============================================================
    // declarations
    logic [13:0]  ctrl_r, ctrl_nxt;     // settings
    logic [31:0]  qty_r, qty_nxt;       // frame quantity
    logic [31:0]  rate_r, rate_nxt;     // frame rate in Hz
    logic [31:0]  dly_r, dly_nxt;       // postponement in us
    logic [31:0]  exp_r, exp_nxt;       // exposure in us
    logic [31:0]  dat_r, dat_nxt;       // read data
    logic         ack_r, ack_nxt;       // bus acknowledge
    fatc_pkg::fatc_state_t st_r, st_nxt;
    logic [31:0]  left_r, left_nxt;     // frames still to take
    logic [31:0]  cnt_r, cnt_nxt;       // frames taken since begin
    logic         halt_r, halt_nxt;     // halt waiting for frame end
    logic         src_r;                // source one cycle ago
    logic [32:0]  acc_r, acc_nxt;       // rate phase accumulator
    logic         fdone_r, fdone_nxt;   // frame end pulse
    logic         acq_r, acq_nxt;       // busy flag, registered for the pin
    logic         wr, rd;               // bus access strobes
    logic [31:0]  wmask;                // byte-lane mask
    logic         begin_p, halt_p;      // command pulses
    logic         src, edge_hit, lvl;   // trigger source view
    logic [1:0]   lsel;                 // chosen line
    logic         rate_tick, free_go, go, fend, width;
    logic         dly_load, exp_load, dly_done, exp_done;
    logic [32:0]  acc_sum;

    // ============================================================
    // wishbone decode: ack a cycle after the request, act on the
    // edge where the master sees ack, so a write lands exactly once
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign rd = wb_cyc_i && wb_stb_i && !ack_r;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign begin_p = wr && wb_adr_i == fatc_pkg::OFS_CMD && wb_sel_i[0]
                     && wb_dat_i[fatc_pkg::KB_BEGIN];
    assign halt_p  = wr && wb_adr_i == fatc_pkg::OFS_CMD && wb_sel_i[0]
                     && wb_dat_i[fatc_pkg::KB_HALT];

    // ============================================================
    // trigger source and edge
    assign lsel  = ctrl_r[fatc_pkg::CB_LSEL +: 2];
    // out-of-range line reads as line zero
    assign src   = ctrl_r[fatc_pkg::CB_SRC]
                   ? ((32'(lsel) < NLINES) ? line_in[lsel] : line_in[0])
                   : ctrl_r[fatc_pkg::CB_SWLVL];
    assign edge_hit = ctrl_r[fatc_pkg::CB_POL] ? (src && !src_r)
                                               : (!src && src_r);
    assign lvl   = ctrl_r[fatc_pkg::CB_POL] ? src : !src;
    // shutter operation picks which trigger type is in use
    assign width = ctrl_r[fatc_pkg::CB_SHUT];

    // ============================================================
    // frame pacing: automatic continuous runs flat out, manual
    // rate ticks from a phase accumulator, no divider needed
    assign acc_sum   = acc_r + {1'b0, rate_r};
    assign rate_tick = acc_sum >= 33'(fatc_pkg::CLK_HZ);
    assign free_go   = ctrl_r[fatc_pkg::CB_ARATE]
                       || !ctrl_r[fatc_pkg::CB_MRATE]
                       || rate_tick;
    // a trigger is heeded only when activation is on
    assign go = ctrl_r[fatc_pkg::CB_TON] ? edge_hit : free_go;
    // frame end: width mode with trigger activation on follows the trigger level
    assign fend = (width && ctrl_r[fatc_pkg::CB_TON]) ? !lvl
                                                      : exp_done;
    assign dly_load = st_r == fatc_pkg::ST_ARMED && go;
    assign exp_load = st_nxt == fatc_pkg::ST_EXPOSE
                      && st_r != fatc_pkg::ST_EXPOSE;

    // ============================================================
    // timers
    fatc_us_timer #(.W(32), .CYC(fatc_pkg::US_CYC)) u_dly (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (dly_load),
        .value   (dly_r),
        .done    (dly_done)
    );
    fatc_us_timer #(.W(32), .CYC(fatc_pkg::US_CYC)) u_exp (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (exp_load),
        .value   (exp_r),
        .done    (exp_done)
    );

    // ============================================================
    // register file next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        qty_nxt  = qty_r;
        rate_nxt = rate_r;
        dly_nxt  = dly_r;
        exp_nxt  = exp_r;
        ack_nxt  = rd;
        dat_nxt  = dat_r;
        if (wr) begin
            unique case (wb_adr_i)
                fatc_pkg::OFS_CTRL: ctrl_nxt = (ctrl_r & ~wmask[13:0])
                                    | (wb_dat_i[13:0] & wmask[13:0]);
                fatc_pkg::OFS_QTY:  qty_nxt  = (qty_r & ~wmask) | (wb_dat_i & wmask);
                fatc_pkg::OFS_RATE: rate_nxt = (rate_r & ~wmask) | (wb_dat_i & wmask);
                fatc_pkg::OFS_DLY:  dly_nxt  = (dly_r & ~wmask) | (wb_dat_i & wmask);
                fatc_pkg::OFS_EXP:  exp_nxt  = (exp_r & ~wmask) | (wb_dat_i & wmask);
                default: ;  // commands, read-only and unmapped
            endcase
        end
        // a single automatic exposure pass ends with a timed-shutter frame
        if (fend && st_r == fatc_pkg::ST_EXPOSE && !width
            && ctrl_nxt[fatc_pkg::CB_AEXP +: 2] == fatc_pkg::AEXP_ONCE) begin
            ctrl_nxt[fatc_pkg::CB_AEXP +: 2] = fatc_pkg::AEXP_OFF;
        end
        if (rd) begin
            unique case (wb_adr_i)
                fatc_pkg::OFS_CTRL: dat_nxt = {18'h00000, ctrl_r};
                fatc_pkg::OFS_QTY:  dat_nxt = qty_r;
                fatc_pkg::OFS_RATE: dat_nxt = rate_r;
                fatc_pkg::OFS_DLY:  dat_nxt = dly_r;
                fatc_pkg::OFS_EXP:  dat_nxt = exp_r;
                fatc_pkg::OFS_STAT: dat_nxt = {26'h0000000, lvl, width, halt_r,
                                    st_r[3], st_r[2], !st_r[0]};
                fatc_pkg::OFS_FRMS: dat_nxt = cnt_r;
                default:            dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // sequencing state machine
    always_comb begin
        st_nxt    = st_r;
        left_nxt  = left_r;
        cnt_nxt   = cnt_r;
        halt_nxt  = halt_r;
        fdone_nxt = 1'b0;
        acc_nxt   = rate_tick ? acc_sum - 33'(fatc_pkg::CLK_HZ) : acc_sum;
        unique case (st_r)
            fatc_pkg::ST_IDLE: begin
                halt_nxt = 1'b0;
                acc_nxt  = 33'h0_0000_0000;
                if (begin_p) begin
                    cnt_nxt = 32'h0000_0000;
                    unique case (ctrl_r[fatc_pkg::CB_SEQ +: 2])
                        fatc_pkg::SEQ_MULTI:  left_nxt = qty_r;
                        default:              left_nxt = 32'h0000_0001;
                    endcase
                    // a zero quantity means nothing to take
                    if (!(ctrl_r[fatc_pkg::CB_SEQ +: 2] == fatc_pkg::SEQ_MULTI
                          && qty_r == 32'h0000_0000)) begin
                        st_nxt = fatc_pkg::ST_ARMED;
                    end
                end
            end
            fatc_pkg::ST_ARMED: begin
                // no frame under way yet, so halt is immediate
                if (halt_p) st_nxt = fatc_pkg::ST_IDLE;
                else if (go) begin
                    st_nxt = (ctrl_r[fatc_pkg::CB_DEN] && dly_r != 32'h0)
                             ? fatc_pkg::ST_DELAY : fatc_pkg::ST_EXPOSE;
                end
            end
            fatc_pkg::ST_DELAY: begin
                if (halt_p) st_nxt = fatc_pkg::ST_IDLE;
                else if (dly_done) st_nxt = fatc_pkg::ST_EXPOSE;
            end
            fatc_pkg::ST_EXPOSE: begin
                // halt only marks; the frame runs to its end
                if (halt_p) halt_nxt = 1'b1;
                if (fend) begin
                    fdone_nxt = 1'b1;
                    cnt_nxt   = cnt_r + 32'h0000_0001;
                    left_nxt  = left_r - 32'h0000_0001;
                    if (halt_r || halt_p
                        || (ctrl_r[fatc_pkg::CB_SEQ +: 2] != fatc_pkg::SEQ_CONT
                            && left_r == 32'h0000_0001)) begin
                        st_nxt = fatc_pkg::ST_IDLE;
                    end else begin
                        st_nxt = fatc_pkg::ST_ARMED;
                    end
                end
            end
            default: st_nxt = fatc_pkg::ST_IDLE;
        endcase
        acq_nxt = !st_nxt[0];  // busy unless heading for idle
    end

    // ============================================================
    // registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r  <= fatc_pkg::CTRL_RST;
            qty_r   <= fatc_pkg::QTY_RST;
            rate_r  <= fatc_pkg::RATE_RST;
            dly_r   <= fatc_pkg::DLY_RST;
            exp_r   <= fatc_pkg::EXP_RST;
            dat_r   <= 32'h0000_0000;
            ack_r   <= 1'b0;
            st_r    <= fatc_pkg::ST_IDLE;
            left_r  <= 32'h0000_0000;
            cnt_r   <= 32'h0000_0000;
            halt_r  <= 1'b0;
            src_r   <= 1'b0;
            acc_r   <= 33'h0_0000_0000;
            fdone_r <= 1'b0;
            acq_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            qty_r   <= qty_nxt;
            rate_r  <= rate_nxt;
            dly_r   <= dly_nxt;
            exp_r   <= exp_nxt;
            dat_r   <= dat_nxt;
            ack_r   <= ack_nxt;
            st_r    <= st_nxt;
            left_r  <= left_nxt;
            cnt_r   <= cnt_nxt;
            halt_r  <= halt_nxt;
            src_r   <= src;
            acc_r   <= acc_nxt;
            fdone_r <= fdone_nxt;
            acq_r   <= acq_nxt;
        end
    end

    // outputs straight from flops
    assign wb_dat_o        = dat_r;
    assign wb_ack_o        = ack_r;
    assign acquiring       = acq_r;
    assign exposure_active = st_r[3];
    assign frame_done_p    = fdone_r;

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_begin_arms: assert property (st_r == fatc_pkg::ST_IDLE && begin_p
        && ctrl_r[1:0] == fatc_pkg::SEQ_CONT |=> st_r == fatc_pkg::ST_ARMED)
        else $error("begin did not arm");
    a_halt_no_abort: assert property (st_r == fatc_pkg::ST_EXPOSE && halt_p
        && !fend |=> st_r == fatc_pkg::ST_EXPOSE ##0 halt_r)
        else $error("halt aborted frame");
    a_count_stop: assert property (st_r == fatc_pkg::ST_EXPOSE && fend
        && ctrl_r[1:0] == fatc_pkg::SEQ_MULTI && left_r == 32'h1
        |=> st_r == fatc_pkg::ST_IDLE && cnt_r == $past(cnt_r) + 32'h1)
        else $error("counted run did not stop");
    a_rate_pace: assert property (st_r == fatc_pkg::ST_ARMED
        && !ctrl_r[2] && ctrl_r[9] && !ctrl_r[10] && !rate_tick && !halt_p
        |=> st_r == fatc_pkg::ST_ARMED)
        else $error("frame without rate tick");
    a_trig_wait: assert property (st_r == fatc_pkg::ST_ARMED && ctrl_r[2]
        && !edge_hit && !halt_p |=> st_r == fatc_pkg::ST_ARMED)
        else $error("frame without trigger edge");
    a_delay_skip: assert property (st_r == fatc_pkg::ST_ARMED && go
        && !halt_p && !ctrl_r[7] |=> st_r == fatc_pkg::ST_EXPOSE)
        else $error("postponement applied while disabled");
    a_delay_len: assert property (st_r == fatc_pkg::ST_ARMED && go
        && !halt_p && ctrl_r[7] && dly_r == 32'h1
        // one microsecond is a hundred cycles; a halt may cut it short
        |=> (st_r == fatc_pkg::ST_DELAY || st_r == fatc_pkg::ST_IDLE)[*8]
        ##93 st_r != fatc_pkg::ST_EXPOSE ##1 st_r != fatc_pkg::ST_DELAY)
        else $error("postponement length wrong");
    a_timed_hold: assert property (st_r == fatc_pkg::ST_EXPOSE
        && !(width && ctrl_r[2]) && !exp_done |=> st_r == fatc_pkg::ST_EXPOSE)
        else $error("timed exposure ended early");
    a_width_end: assert property (st_r == fatc_pkg::ST_EXPOSE && width
        && ctrl_r[2] && !lvl |=> !exposure_active && frame_done_p ##1 !frame_done_p)
        else $error("width exposure did not end");
    a_single_stop: assert property (st_r == fatc_pkg::ST_EXPOSE && fend
        && ctrl_r[1:0] == fatc_pkg::SEQ_SINGLE |=> st_r == fatc_pkg::ST_IDLE)
        else $error("single frame run did not stop");
    a_edge_pick: assert property (st_r == fatc_pkg::ST_ARMED && ctrl_r[2]
        && !ctrl_r[3] && !$past(ctrl_r[3]) && ctrl_r[6] && ctrl_r[13]
        && !$past(ctrl_r[13]) && !halt_p |=> st_r != fatc_pkg::ST_ARMED)
        else $error("rising software edge missed");
    a_once_clear: assert property (st_r == fatc_pkg::ST_EXPOSE && fend
        && !width && ctrl_r[12:11] == fatc_pkg::AEXP_ONCE && !wr
        |=> ctrl_r[12:11] == fatc_pkg::AEXP_OFF)
        else $error("single exposure pass not cleared");
    a_width_hold: assert property (st_r == fatc_pkg::ST_EXPOSE && width
        && ctrl_r[2] && lvl |=> st_r == fatc_pkg::ST_EXPOSE)
        else $error("width exposure ended while trigger active");
    a_ack_pulse: assert property (rd |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");
endmodule // fatc_core

// *** inc/fatc_pkg.sv ***
// constants and types of the frame acquisition and trigger controller
// ============================================================
// Functional notes
// - sequencing: continuous, single frame, counted frames
// - begin command starts capture per sequencing
// - halt command waits for current frame end
// - counted mode stops after frame quantity
// - manual rate paces frames in hertz
// - automatic rate: off or continuous
// - trigger honoured only when activation on
// - trigger origin: software or input line
// - trigger edge chosen by polarity setting
// - postponement in microseconds before trigger acts
// - postponement applied only when enabled
// - shutter operation forces trigger type selector
// - timed shutter exposes for duration setting
// - automatic exposure: off, once, continuous
package fatc_pkg;
    // ============================================================
    // timing
    localparam int CLK_HZ   = 100_000_000;  // sys_clk rate
    localparam int CLK_NS   = 10;           // sys_clk period
    localparam int US_NS    = 1000;         // one microsecond in ns
    localparam int US_CYC   = US_NS / CLK_NS;
    // ============================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;  // settings
    localparam logic [7:0] OFS_CMD   = 8'h04;  // write-only commands
    localparam logic [7:0] OFS_QTY   = 8'h08;  // frame quantity
    localparam logic [7:0] OFS_RATE  = 8'h0c;  // frame rate, Hz
    localparam logic [7:0] OFS_DLY   = 8'h10;  // postponement, us
    localparam logic [7:0] OFS_EXP   = 8'h14;  // exposure, us
    localparam logic [7:0] OFS_STAT  = 8'h18;  // status, read-only
    localparam logic [7:0] OFS_FRMS  = 8'h1c;  // frames captured
    // ============================================================
    // control field positions
    localparam int CB_SEQ   = 0;   // [1:0] sequencing setting
    localparam int CB_TON   = 2;   // trigger activation
    localparam int CB_SRC   = 3;   // 0 software, 1 line
    localparam int CB_LSEL  = 4;   // [5:4] line number
    localparam int CB_POL   = 6;   // 0 falling, 1 rising
    localparam int CB_DEN   = 7;   // postponement enable
    localparam int CB_SHUT  = 8;   // 0 timed, 1 trigger width
    localparam int CB_MRATE = 9;   // manual rate enable
    localparam int CB_ARATE = 10;  // automatic rate setting
    localparam int CB_AEXP  = 11;  // [12:11] automatic exposure
    localparam int CB_SWLVL = 13;  // software trigger level
    localparam int CTRL_W   = 14;
    // command bits
    localparam int KB_BEGIN = 0;
    localparam int KB_HALT  = 1;
    // ============================================================
    // reset values
    localparam logic [13:0] CTRL_RST = 14'h0000;
    localparam logic [31:0] QTY_RST  = 32'h0000_0001;
    localparam logic [31:0] RATE_RST = 32'h0000_001e;
    localparam logic [31:0] DLY_RST  = 32'h0000_0000;
    localparam logic [31:0] EXP_RST  = 32'h0000_2710;
    // ============================================================
    // types
    typedef enum logic [1:0] {
        SEQ_CONT   = 2'h0,
        SEQ_SINGLE = 2'h1,
        SEQ_MULTI  = 2'h2
    } fatc_seq_t;
    typedef enum logic [1:0] {
        AEXP_OFF  = 2'h0,
        AEXP_ONCE = 2'h1,
        AEXP_CONT = 2'h2
    } fatc_aexp_t;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ARMED  = 4'h2,
        ST_DELAY  = 4'h4,
        ST_EXPOSE = 4'h8
    } fatc_state_t;
endpackage

// *** rtl/fatc_us_timer.sv ***
// microsecond down-timer with its own prescaler
`timescale 1ns/1ps
module fatc_us_timer #(
    parameter int W   = 32,
    parameter int CYC = fatc_pkg::US_CYC
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // result
    output logic              done
);
    // ============================================================
    // elaboration check
    if (CYC < 1 || CYC > 65536 || W < 1) begin : g_chk
        $error("fatc_us_timer: bad parameters");
    end

    logic [W-1:0]  cnt_r, cnt_nxt;   // microseconds left
    logic [15:0]   pre_r, pre_nxt;   // cycles into current us
    logic          tick;             // one-cycle us enable

    // prescaler restarts with load so durations stay exact
    assign tick = (pre_r == 16'(CYC - 1));
    // done reads the count only, so it never loops back through load
    assign done = (cnt_r == '0);

    // ============================================================
    // next values
    always_comb begin
        pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
        cnt_nxt = cnt_r;
        if (load) begin
            pre_nxt = 16'h0000;
            cnt_nxt = value;
        end else if (tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= 16'h0000;
            cnt_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule // fatc_us_timer

// *** bench/fatc_trig_model.sv ***
// trigger line model standing in for the external trigger source
`timescale 1ns/1ps
module fatc_trig_model (
    // clock
    input  wire logic       sys_clk,
    // line setup
    input  wire logic       pol,
    input  wire logic [1:0] lsel,
    // trigger lines
    output logic      [3:0] line_in
);
    // ============================================================
    // line levels
    logic act = 1'b0;  // selected line held at its active level
    // idle lines rest at the level opposite the chosen edge, as a pull would
    assign line_in = {4{~pol}} ^ ({3'h0, act} << lsel);
    // active span in cycles; changes land only just after an edge
    task automatic pulse(input int w);
        @(posedge sys_clk);
        act <= 1'b1;
        repeat (w) @(posedge sys_clk);
        act <= 1'b0;
    endtask
endmodule // fatc_trig_model

// *** bench/test_frame_acquisition_trigger_control.sv ***
// self-checking bench of the frame acquisition and trigger controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_frame_acquisition_trigger_control;
    // ============================================================
    // stimulus and observed signals
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat     = 32'h0;
    logic [3:0]  sel     = 4'hf;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, acquiring, exposure_active, frame_done_p;
    logic [3:0]  line_in;
    logic        m_pol   = 1'b1;  // model: active level of the line
    logic [1:0]  m_lsel  = 2'h0;  // model: which line pulses
    int          errors = 0, total_checks = 0, n, n2;
    // reset values, unmapped address last
    logic [7:0]  rv_a [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    logic [31:0] rv_d [6] = '{32'h0, 32'h1, 32'h1e, 32'h0, 32'h2710, 32'h0};
    // postponement on, then off: control word and window of rise latency
    logic [31:0] dl_c [2] = '{32'h9d, 32'h1d};
    int          dl_lo [2] = '{100, 1};
    int          dl_hi [2] = '{104, 4};
    always #5 sys_clk = ~sys_clk;
    // ============================================================
    // design and line model
    fatc_core #(.NLINES(4)) DUT (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_in(line_in),
        .acquiring(acquiring), .exposure_active(exposure_active),
        .frame_done_p(frame_done_p));
    fatc_trig_model tm (.sys_clk(sys_clk), .pol(m_pol), .lsel(m_lsel), .line_in(line_in));
    // ============================================================
    // closing report
    task automatic give_verdict();
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // a bound ran out: count it and close
    task automatic timeout();
        errors++;
        $display("MISMATCH wait exp done got timeout");
        give_verdict();
    endtask
    // one classic cycle; request held until ack is sampled at an edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) timeout();
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // cycles until exposure_active shows v
    task automatic wait_exp(input logic v, output int c);
        c = 0;
        while (exposure_active !== v) begin
            @(posedge sys_clk);
            c++;
            if (c > 5000) timeout();
        end
    endtask
    // frame pulses counted until the controller is idle again
    task automatic run_idle(output int f);
        int c;
        f = 0;
        c = 0;
        while (acquiring !== 1'b1 && c < 10) begin
            @(posedge sys_clk);
            c++;
        end
        do begin
            @(posedge sys_clk);
            c++;
            if (frame_done_p === 1'b1) f++;
            if (c > 20000) timeout();
        end while (acquiring !== 1'b0);
        // the pulse trails the frame end by a cycle
        repeat (3) begin
            @(posedge sys_clk);
            if (frame_done_p === 1'b1) f++;
        end
    endtask
    // ============================================================
    // scenarios
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            xfer(rv_a[i], 1'b0, 32'h0);
            `CHK("reset value", rv_d[i], rd);
        end
        // single timed frame, trigger off, one-shot auto exposure
        xfer(8'h14, 1'b1, 32'h2);
        xfer(8'h00, 1'b1, 32'h801);
        xfer(8'h04, 1'b1, 32'h1);
        wait_exp(1'b1, n);
        wait_exp(1'b0, n);
        `CHK("timed exposure", 1'b1, (n >= 199 && n <= 203));
        run_idle(n);
        xfer(8'h1c, 1'b0, 32'h0);
        `CHK("single frames", 32'h1, rd);
        xfer(8'h00, 1'b0, 32'h0);
        `CHK("once clears", 32'h1, rd);
        // counted frames
        xfer(8'h14, 1'b1, 32'h1);
        xfer(8'h08, 1'b1, 32'h3);
        xfer(8'h00, 1'b1, 32'h2);
        xfer(8'h04, 1'b1, 32'h1);
        run_idle(n);
        `CHK("frame pulses", 1'b1, (n == 3));
        xfer(8'h1c, 1'b0, 32'h0);
        `CHK("counted frames", 32'h3, rd);
        // continuous at manual rate, then halt mid-exposure
        xfer(8'h0c, 1'b1, 32'h186a0);
        xfer(8'h00, 1'b1, 32'h200);
        xfer(8'h04, 1'b1, 32'h1);
        wait_exp(1'b1, n);
        wait_exp(1'b0, n);
        wait_exp(1'b1, n2);
        `CHK("frame period", 1'b1, (n + n2 >= 995 && n + n2 <= 1005));
        xfer(8'h00, 1'b1, 32'h600);
        wait_exp(1'b0, n);
        wait_exp(1'b1, n2);
        `CHK("auto rate", 1'b1, (n + n2 < 900));
        xfer(8'h04, 1'b1, 32'h2);
        xfer(8'h18, 1'b0, 32'h0);
        `CHK("halt pending", 32'hd, rd & 32'hd);
        wait_exp(1'b0, n);
        `CHK("frame kept", 1'b1, (n >= 85));
        run_idle(n);
        // trigger width from line 2, rising
        m_pol  <= 1'b1;
        m_lsel <= 2'h2;
        xfer(8'h00, 1'b1, 32'h16d);
        xfer(8'h04, 1'b1, 32'h1);
        xfer(8'h18, 1'b0, 32'h0);
        `CHK("width armed", 32'h11, rd & 32'h15);
        `CHK("no edge yet", 1'b0, exposure_active);
        fork tm.pulse(50); join_none
        wait_exp(1'b1, n);
        wait_exp(1'b0, n);
        `CHK("width exposure", 1'b1, (n >= 49 && n <= 51));
        run_idle(n);
        // timed on falling edge of line 1, postponed and not
        m_pol  <= 1'b0;
        m_lsel <= 2'h1;
        xfer(8'h10, 1'b1, 32'h1);
        for (int i = 0; i < 2; i++) begin
            xfer(8'h00, 1'b1, dl_c[i]);
            xfer(8'h04, 1'b1, 32'h1);
            fork tm.pulse(5); join_none
            wait_exp(1'b1, n);
            `CHK("trigger latency", 1'b1, (n >= dl_lo[i] && n <= dl_hi[i]));
            run_idle(n);
        end
        // software trigger, rising
        xfer(8'h00, 1'b1, 32'h45);
        xfer(8'h04, 1'b1, 32'h1);
        xfer(8'h00, 1'b1, 32'h2045);
        wait_exp(1'b1, n);
        `CHK("soft trigger", 1'b1, (n <= 5));
        run_idle(n);
        // byte lanes: only lane one of the quantity may change
        sel <= 4'h2;
        xfer(8'h08, 1'b1, 32'haaaa_aaaa);
        sel <= 4'hf;
        xfer(8'h08, 1'b0, 32'h0);
        `CHK("byte lanes", 32'h0000_aa03, rd);
        give_verdict();
    end
endmodule // test_frame_acquisition_trigger_control
